// *** core/iolc_change.sv ***
// sampled pin level and change detector
`timescale 1ns/100ps
`default_nettype none
module iolc_change (
  input wire logic aclk, // master clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [31:0] level_in, // filtered level
  output logic [31:0] level_q, // current sample
  output logic [31:0] changed // one-cycle change pulses
);
  // ****************************************************************
  // two successive samples
  // ****************************************************************
  typedef struct packed {
    logic [31:0] cur;
    logic [31:0] prev;
    logic primed;
  } iolc_ch_t;
  iolc_ch_t st;
  iolc_ch_t next_st;
  // no clock, no samples: level simply holds
  always_comb begin
    next_st = st;
    next_st.cur = level_in;
    // first sample after reset loads both, so the reset value of cur
    // can never look like an edge on a line that idles high
    next_st.prev = st.primed ? st.cur : level_in;
    next_st.primed = 1'b1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign level_q = st.cur;
  // primed blocks a false change from the reset value
  assign changed = st.primed ? (st.cur ^ st.prev) : 32'h0000_0000;
endmodule
`default_nettype wire

// *** core/iolc_glitch.sv ***
// per-line half-cycle glitch filter sampled on both clock edges
`timescale 1ns/100ps
`default_nettype none
module iolc_glitch (
  input wire logic aclk, // master clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [31:0] pin_in, // raw pin levels
  input wire logic [31:0] filt_en, // per-line filter enable
  output logic [31:0] level_out // filtered or raw level
);
  // ****************************************************************
  // dual-edge sampling
  // ****************************************************************
  typedef struct packed {
    logic [31:0] flt;
  } iolc_gf_t;
  iolc_gf_t st;
  iolc_gf_t next_st;
  logic [31:0] fall_q;
  // falling-edge sample; only this one register uses the low phase
  always_ff @(negedge aclk) begin
    fall_q <= pin_in;
  end
  // a level accepted only if both half-cycle samples agree
  always_comb begin
    next_st = st;
    for (int i = 0; i < iolc_pkg::LINES; i++) begin
      if (pin_in[i] == fall_q[i]) begin
        next_st.flt[i] = pin_in[i];
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  // bypass chosen by the filter status bit only
  assign level_out = (filt_en & st.flt) | (~filt_en & pin_in);
endmodule
`default_nettype wire

// *** core/iolc_top.sv ***
// i/o line controller top: axi4-lite registers, output drive, change irq
`timescale 1ns/100ps
`default_nettype none
module iolc_top (
  input wire logic aclk, // master clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [31:0] pin_in, // pin levels
  output logic [31:0] pin_out, // pin drive value
  output logic [31:0] pin_oe, // pin drive enable
  input wire logic [31:0] line_owned, // 1 = controller owns line
  input wire logic [31:0] periph_out, // peripheral drive value
  input wire logic [31:0] periph_oe, // peripheral drive enable
  output logic [31:0] periph_in, // pin level to peripherals
  output logic irq // ored change interrupt
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] out_en;
    logic [31:0] latch;
    logic [31:0] dw_mask;
    logic [31:0] od;
    logic [31:0] flt_en;
    logic [31:0] irq_mask;
    logic [31:0] irq_sts;
    logic [31:0] pin_out;
    logic [31:0] pin_oe;
    logic [31:0] periph_in;
    logic irq;
  } iolc_st_t;
  iolc_st_t st;
  iolc_st_t next_st;
  logic [31:0] filt_level;
  logic [31:0] level_q;
  logic [31:0] changed;

  // expands byte strobes to a bit mask, limited to real lines
  function automatic logic [31:0] strb_bits(input logic [3:0] s);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{s[b]}};
    end
    return m & iolc_pkg::LINE_MASK;
  endfunction

  // set/clear helper: zero bits leave the target alone
  function automatic logic [31:0] set_bits(input logic [31:0] cur, input logic [31:0] ones);
    return cur | ones;
  endfunction
  function automatic logic [31:0] clr_bits(input logic [31:0] cur, input logic [31:0] ones);
    return cur & ~ones;
  endfunction

  // ****************************************************************
  // input path
  // ****************************************************************
  iolc_glitch u_glitch (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(pin_in),
    .filt_en(st.flt_en),
    .level_out(filt_level)
  );
  iolc_change u_change (
    .aclk(aclk),
    .aresetn(aresetn),
    .level_in(filt_level),
    .level_q(level_q),
    .changed(changed)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [31:0] wm;
    logic [31:0] wv;
    logic [31:0] drv;
    logic [31:0] en;
    logic do_write;
    logic rd_clr;
    logic ok;
    wm = 32'h0000_0000;
    wv = 32'h0000_0000;
    drv = 32'h0000_0000;
    en = 32'h0000_0000;
    do_write = 1'b0;
    rd_clr = 1'b0;
    ok = 1'b0;
    next_st = st;
    // write address and data captured in either order
    next_st.awready = 1'b0;
    next_st.wready = 1'b0;
    if (!st.aw_got && !st.bvalid) begin
      next_st.awready = !(s_axi_awvalid && st.awready);
    end
    if (!st.w_got && !st.bvalid) begin
      next_st.wready = !(s_axi_wvalid && st.wready);
    end
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
      next_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
      next_st.wready = 1'b0;
    end
    do_write = st.aw_got && st.w_got && !st.bvalid;
    if (do_write) begin
      wm = strb_bits(st.w_strb);
      wv = st.w_data & wm;
      ok = 1'b1;
      unique case (st.aw_addr & 8'hfc)
        iolc_pkg::OFS_OUT_EN_SET: next_st.out_en = set_bits(st.out_en, wv);
        iolc_pkg::OFS_OUT_EN_CLR: next_st.out_en = clr_bits(st.out_en, wv);
        iolc_pkg::OFS_FLT_SET: next_st.flt_en = set_bits(st.flt_en, wv);
        iolc_pkg::OFS_FLT_CLR: next_st.flt_en = clr_bits(st.flt_en, wv);
        iolc_pkg::OFS_DATA_SET: next_st.latch = set_bits(st.latch, wv);
        iolc_pkg::OFS_DATA_CLR: next_st.latch = clr_bits(st.latch, wv);
        iolc_pkg::OFS_DATA_LATCH: begin
          // only bits set in dw_mask take the new value
          en = st.dw_mask & wm;
          next_st.latch = (st.latch & ~en) | (st.w_data & en);
        end
        iolc_pkg::OFS_IRQ_SET: next_st.irq_mask = set_bits(st.irq_mask, wv);
        iolc_pkg::OFS_IRQ_CLR: next_st.irq_mask = clr_bits(st.irq_mask, wv);
        iolc_pkg::OFS_OD_SET: next_st.od = set_bits(st.od, wv);
        iolc_pkg::OFS_OD_CLR: next_st.od = clr_bits(st.od, wv);
        iolc_pkg::OFS_DW_SET: next_st.dw_mask = set_bits(st.dw_mask, wv);
        iolc_pkg::OFS_DW_CLR: next_st.dw_mask = clr_bits(st.dw_mask, wv);
        iolc_pkg::OFS_OUT_EN_STS, iolc_pkg::OFS_FLT_STS, iolc_pkg::OFS_PIN_LEVEL,
        iolc_pkg::OFS_IRQ_MASK, iolc_pkg::OFS_IRQ_STS, iolc_pkg::OFS_OD_STS,
        iolc_pkg::OFS_DW_STS: ok = 1'b1;
        default: ok = 1'b0;
      endcase
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = ok ? iolc_pkg::RESP_OKAY : iolc_pkg::RESP_SLVERR;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    // read: arready pulses, data one cycle after the address is taken
    next_st.arready = !st.rvalid && !(s_axi_arvalid && st.arready) && !st.arready;
    if (s_axi_arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rresp = iolc_pkg::RESP_OKAY;
      unique case (s_axi_araddr & 8'hfc)
        iolc_pkg::OFS_OUT_EN_STS: next_st.rdata = st.out_en;
        iolc_pkg::OFS_FLT_STS: next_st.rdata = st.flt_en;
        iolc_pkg::OFS_DATA_LATCH: next_st.rdata = st.latch;
        iolc_pkg::OFS_PIN_LEVEL: next_st.rdata = level_q;
        iolc_pkg::OFS_IRQ_MASK: next_st.rdata = st.irq_mask;
        iolc_pkg::OFS_IRQ_STS: begin
          // include a change arriving this cycle so it is not lost
          next_st.rdata = st.irq_sts | changed;
          rd_clr = 1'b1;
        end
        iolc_pkg::OFS_OD_STS: next_st.rdata = st.od;
        iolc_pkg::OFS_DW_STS: next_st.rdata = st.dw_mask;
        iolc_pkg::OFS_OUT_EN_SET, iolc_pkg::OFS_OUT_EN_CLR, iolc_pkg::OFS_FLT_SET,
        iolc_pkg::OFS_FLT_CLR, iolc_pkg::OFS_DATA_SET, iolc_pkg::OFS_DATA_CLR,
        iolc_pkg::OFS_IRQ_SET, iolc_pkg::OFS_IRQ_CLR, iolc_pkg::OFS_OD_SET,
        iolc_pkg::OFS_OD_CLR, iolc_pkg::OFS_DW_SET,
        iolc_pkg::OFS_DW_CLR: next_st.rdata = 32'h0000_0000;
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = iolc_pkg::RESP_SLVERR;
        end
      endcase
      next_st.rdata = next_st.rdata & iolc_pkg::LINE_MASK;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    // change status: read clears all, but a new change wins
    if (rd_clr) begin
      next_st.irq_sts = changed & iolc_pkg::LINE_MASK;
    end else begin
      next_st.irq_sts = (st.irq_sts | changed) & iolc_pkg::LINE_MASK;
    end
    // one ored line for all masked pending changes
    next_st.irq = |(next_st.irq_sts & next_st.irq_mask);
    // ****************************************************************
    // output drive; open drain lines drive only a low
    // ****************************************************************
    drv = (line_owned & next_st.latch) | (~line_owned & periph_out);
    en = (line_owned & next_st.out_en) | (~line_owned & periph_oe);
    next_st.pin_out = drv & ~next_st.od;
    next_st.pin_oe = en & ~(next_st.od & drv);
    // peripherals always see the raw pin
    next_st.periph_in = pin_in;
  end

  // ****************************************************************
  // register
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.dw_mask <= iolc_pkg::RST_ZERO;
      st.od <= iolc_pkg::RST_ZERO;
      st.irq_sts <= iolc_pkg::RST_ZERO;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign pin_out = st.pin_out;
  assign pin_oe = st.pin_oe;
  assign periph_in = st.periph_in;
  assign irq = st.irq;
endmodule
`default_nettype wire

// *** dv/iolc_assertions.sv ***
// concurrent checks on the ports of the line controller top
`timescale 1ns/100ps
`default_nettype none
module iolc_checker (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // b resp
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic [1:0] s_axi_rresp, // r resp
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic [31:0] pin_in, // pads
  input wire logic [31:0] periph_in, // to peripherals
  input wire logic irq // change irq
);
  // ****************************************
  // properties
  // ****************************************
  // one clock domain, so reset masks all but the reset check
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_periph_raw: assert property ($past(aresetn) |-> periph_in == $past(pin_in))
    else $error("peripheral input not the raw pin level");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_write_answer: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:40] s_axi_bvalid)
    else $error("write not answered");
  a_busy_closed: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while response pending");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == iolc_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
    else $error("refused read returned data");
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active in reset");
  a_ready_open: assert property ($rose(aresetn) |=> s_axi_awready && s_axi_wready && s_axi_arready)
    else $error("readies closed after reset");
endmodule
bind iolc_top iolc_checker chk_i (.*);
`default_nettype wire

// *** dv/iolc_pad_model.sv ***
// pad model: pull-ups, outside drivers and wired-low sharing on the 32 lines
`timescale 1ns/100ps
`default_nettype none
module iolc_pad_model (
  input wire logic [31:0] pin_out, // controller drive value
  input wire logic [31:0] pin_oe, // controller drive enable
  input wire logic [31:0] ext_val, // outside driver value
  input wire logic [31:0] ext_oe, // outside driver enable
  output logic [31:0] pin_in // resolved pad level
);
  // ****************************************
  // pad resolution
  // ****************************************
  // any party driving low wins, else the pull-up gives high
  assign pin_in = ~((pin_oe & ~pin_out) | (ext_oe & ~ext_val));
endmodule
`default_nettype wire

// *** dv/iolc_top_tb.sv ***
// self-checking bench for the line controller top
`timescale 1ns/100ps
`default_nettype none
module iolc_top_tb;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  localparam logic [1:0] OK = iolc_pkg::RESP_OKAY;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, line_owned = 0, periph_out = 0, periph_oe = 0, ext_val = 0;
  logic [31:0] ext_oe = 0, s_axi_rdata, pin_in, pin_out, pin_oe, periph_in, lat, a, b, g, t;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [7:0] rz [7];
  int num_errors = 0, num_checks = 0;
  iolc_top dut (.*);
  iolc_pad_model pads (.*);
  // ****************************************
  // helpers
  // ****************************************
  always #12.5 aclk = ~aclk;
  function automatic logic [31:0] upd(logic [31:0] o, s, c);
    return (o | s) & ~c;
  endfunction
  function automatic logic [31:0] dwr(logic [31:0] o, v, m);
    return (o & ~m) | (v & m);
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // an edge passes first so no strobe is assigned twice in one step
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    chk(32'(s_axi_bvalid), 32'h1);
    chk(32'(s_axi_bresp), 32'(er));
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [1:0] er, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata;
    chk(32'(s_axi_rvalid), 32'h1);
    chk(32'(s_axi_rresp), 32'(er));
    s_axi_rready <= 1'b0;
  endtask
  // pulse of w ns on lines t, starting s ns after a rising edge
  task automatic pulse(input int s, input int w);
    @(posedge aclk);
    #s;
    ext_val = ext_val ^ t;
    #w;
    chk(periph_in, pin_in);
    ext_val = ext_val ^ t;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    void'($urandom(90989));
    rz = '{iolc_pkg::OFS_OUT_EN_STS, iolc_pkg::OFS_FLT_STS, iolc_pkg::OFS_IRQ_MASK,
      iolc_pkg::OFS_OD_STS, iolc_pkg::OFS_DW_STS, iolc_pkg::OFS_DATA_LATCH, iolc_pkg::OFS_IRQ_STS};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rz[i]) begin
      rd(rz[i], OK, g);
      chk(g, 32'h0);
    end
    $display("test reset values done");
    // set then clear with random words, owner random
    for (int i = 0; i < 5; i++) begin
      a = $urandom;
      b = $urandom;
      line_owned <= $urandom;
      wr(rz[i] - 8'h08, a, OK);
      wr(rz[i] - 8'h04, b, OK);
      rd(rz[i], OK, g);
      chk(g, upd(32'h0, a, b));
      wr(rz[i] - 8'h04, ALL, OK);
    end
    wr(8'hfc, ALL, iolc_pkg::RESP_SLVERR);
    rd(8'hfc, iolc_pkg::RESP_SLVERR, g);
    chk(g, 32'h0);
    wr(iolc_pkg::OFS_OUT_EN_STS, ALL, OK);
    rd(iolc_pkg::OFS_OUT_EN_STS, OK, g);
    chk(g, 32'h0);
    $display("test set clear done");
    // latch written while peripherals own every line
    line_owned <= 32'h0;
    a = $urandom;
    b = $urandom;
    wr(iolc_pkg::OFS_OUT_EN_SET, ALL, OK);
    wr(iolc_pkg::OFS_DATA_SET, a, OK);
    wr(iolc_pkg::OFS_DATA_CLR, b, OK);
    lat = upd(32'h0, a, b);
    rd(iolc_pkg::OFS_DATA_LATCH, OK, g);
    chk(g, lat);
    line_owned <= ALL;
    repeat (2) @(posedge aclk);
    chk(pin_oe, ALL);
    chk(pin_out, lat);
    a = $urandom;
    b = $urandom;
    wr(iolc_pkg::OFS_DW_SET, a, OK);
    wr(iolc_pkg::OFS_DATA_LATCH, b, OK);
    lat = dwr(lat, b, a);
    rd(iolc_pkg::OFS_DATA_LATCH, OK, g);
    chk(g, lat);
    wr(iolc_pkg::OFS_OD_SET, ALL, OK);
    repeat (2) @(posedge aclk);
    chk(pin_oe, ~lat);
    chk(pin_oe & pin_out, 32'h0);
    wr(iolc_pkg::OFS_OD_CLR, ALL, OK);
    wr(iolc_pkg::OFS_OUT_EN_CLR, ALL, OK);
    $display("test output drive done");
    line_owned <= $urandom;
    periph_out <= $urandom;
    periph_oe <= $urandom;
    ext_oe <= $urandom;
    ext_val <= $urandom;
    repeat (4) @(posedge aclk);
    rd(iolc_pkg::OFS_PIN_LEVEL, OK, g);
    chk(g, pin_in);
    $display("test pin level done");
    // outside drivers own the pads from here on
    periph_oe <= 32'h0;
    ext_oe <= ALL;
    repeat (5) @(posedge aclk);
    for (int k = 0; k < 4; k++) begin
      rd(iolc_pkg::OFS_IRQ_STS, OK, g);
      a = (k == 0) ? 32'h0000_0001 : $urandom;
      t = (k == 0) ? 32'h8000_0000 : $urandom;
      wr(iolc_pkg::OFS_IRQ_SET, a, OK);
      ext_val <= ext_val ^ t;
      repeat (5) @(posedge aclk);
      chk(32'(irq), 32'(|(t & a)));
      rd(iolc_pkg::OFS_IRQ_STS, OK, g);
      chk(g, t);
      rd(iolc_pkg::OFS_IRQ_STS, OK, g);
      chk(g, 32'h0);
      chk(32'(irq), 32'h0);
      wr(iolc_pkg::OFS_IRQ_CLR, ALL, OK);
    end
    $display("test change irq done");
    // short pulse filtered, unfiltered, then a full cycle pulse filtered
    for (int k = 0; k < 3; k++) begin
      t = $urandom;
      wr(k == 1 ? iolc_pkg::OFS_FLT_CLR : iolc_pkg::OFS_FLT_SET, ALL, OK);
      rd(iolc_pkg::OFS_IRQ_STS, OK, g);
      pulse(k == 2 ? 2 : 22, k == 2 ? 25 : 10);
      repeat (6) @(posedge aclk);
      rd(iolc_pkg::OFS_IRQ_STS, OK, g);
      chk(g, k == 0 ? 32'h0 : t);
    end
    $display("test glitch filter done");
    close_out;
  end
  initial begin
    #(25 * 20000);
    num_errors++;
    $display("unexpected at %0t: run hung", $time);
    close_out;
  end
endmodule
`default_nettype wire

// *** include/iolc_pkg.sv ***
// package of offsets, reset values and widths for the i/o line controller
// ****************************************************************
// Notes on behaviour
// - output enable writes act regardless of ownership
// - data set/clear writes act regardless of ownership
// - direct latch write touches masked bits only
// - mask set/clear writes ones set/clear mask
// - direct write mask resets to zero
// - open drain lines only ever pull low
// - open drain set/clear works for any owner
// - open drain status resets to zero
// - pin level status shows sampled pin levels
// - pin level holds while clock gated
// - filter rejects half cycle, passes full cycle
// - filter latency one cycle after rising sample
// - filter status bit alone enables filter
// - peripherals see unfiltered pin level
// - irq set/clear writes update irq mask
// - change found by two successive clocked samples
// - change detection on every line always
// - change sets status; masked status raises irq
// - all line interrupts ored into one
// - status read clears all pending bits
// - unimplemented lines ignore writes, read zero
// - change status resets to zero
// ****************************************************************
package iolc_pkg;
  localparam int unsigned LINES = 32;
  localparam logic [31:0] LINE_MASK = 32'hffff_ffff;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_OWNED = 32'hffff_ffff;
  localparam logic [7:0] OFS_OUT_EN_SET = 8'h10;
  localparam logic [7:0] OFS_OUT_EN_CLR = 8'h14;
  localparam logic [7:0] OFS_OUT_EN_STS = 8'h18;
  localparam logic [7:0] OFS_FLT_SET = 8'h20;
  localparam logic [7:0] OFS_FLT_CLR = 8'h24;
  localparam logic [7:0] OFS_FLT_STS = 8'h28;
  localparam logic [7:0] OFS_DATA_SET = 8'h30;
  localparam logic [7:0] OFS_DATA_CLR = 8'h34;
  localparam logic [7:0] OFS_DATA_LATCH = 8'h38;
  localparam logic [7:0] OFS_PIN_LEVEL = 8'h3c;
  localparam logic [7:0] OFS_IRQ_SET = 8'h40;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h44;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h48;
  localparam logic [7:0] OFS_IRQ_STS = 8'h4c;
  localparam logic [7:0] OFS_OD_SET = 8'h50;
  localparam logic [7:0] OFS_OD_CLR = 8'h54;
  localparam logic [7:0] OFS_OD_STS = 8'h58;
  localparam logic [7:0] OFS_DW_SET = 8'ha0;
  localparam logic [7:0] OFS_DW_CLR = 8'ha4;
  localparam logic [7:0] OFS_DW_STS = 8'ha8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
